/* design/event_counter_cell.v */
// One 32-bit event counter with a software load port.
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_defs.vh"

module event_counter_cell (
  input  wire        clk_i,    // Core clock.
  input  wire        rstn_i,   // Asynchronous reset, active low.
  input  wire        load_i,   // Software write strobe.
  input  wire [31:0] load_val_i, // Value written by software.
  input  wire        run_i,    // Counting allowed this cycle.
  input  wire [2:0]  inc_i,    // Amount to add this cycle.
  output reg  [31:0] count_o   // Current count; bit 31 is the sign.
);

  // A software load wins over a count in the same cycle, so the written
  // value is never disturbed by a stray event.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_o <= `COUNTER_RESET;
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (run_i) begin
      count_o <= count_o + {29'h0, inc_i};
    end
  end

endmodule // event_counter_cell
`default_nettype wire

/* design/perf_event_counters.v */
// Four performance event counters with their monitor control register.
//
// What this block does
// - Four 32-bit counters; sign bit means negative.
// - Negative raises request only with both enables.
// - Request recorded; taken only when mask set.
// - Freeze bit stops all counters on interrupt.
// - Counters at register numbers 953, 954, 957, 958.
// - Count until interrupt with freeze bit set; one, two from control write, three, four from reset.
// - Select zero holds counter one.
// - Select one counts every clock.
// - Select two adds instructions completed.
// - Select three counts chosen time-base transitions.
// - Selects four-seven: dispatch, misses, mispredicts.
// - Select eight counts reservation requests.
// - Threshold load/store miss counts, intervention split.
// - Special-move, barrier, ordered-I/O barrier counts.
// - Integer and float completions added per cycle.
// - Result counts: load/store, simple integer, float.
// - Dispatch counts per execution unit.
// - Count all valid outside snoop requests.
// - Branch and multi-cycle unit idle cycles.
// - Count intervention signal assertions.
// - Unaligned loads and breakpoint hits.
// - Counter one selector is seven bits.
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_defs.vh"

module perf_event_counters (
  input  wire        clk_i,                  // Core clock, 40 MHz.
  input  wire        rstn_i,                 // Asynchronous reset, active low.
  // Special-purpose register move port.
  input  wire        spr_wr_i,               // Move-to strobe, one cycle.
  input  wire        spr_rd_i,               // Move-from strobe, one cycle.
  input  wire [9:0]  spr_num_i,              // Register number.
  input  wire [31:0] spr_wdata_i,            // Data for a move-to.
  output reg  [31:0] spr_rdata_o,            // Data for a move-from.
  output reg         spr_rvalid_o,           // Read data valid, one cycle.
  // Core state.
  input  wire        external_irq_mask_bit_i, // Core accepts interrupts.
  input  wire [63:0] timebase_i,             // Core time base.
  // Pipeline event sources, all on the core clock.
  input  wire [2:0]  instr_completed_i,      // Instructions completed this cycle.
  input  wire [2:0]  int_completed_i,        // Integer completions, no loads/stores.
  input  wire [2:0]  fp_completed_i,         // Float completions, no loads/stores.
  input  wire [2:0]  instr_dispatched_i,     // Instructions dispatched this cycle.
  input  wire        icache_miss_i,          // Instruction cache miss.
  input  wire        dtlb_miss_i,            // Data translation buffer miss.
  input  wire        br_mispredict_i,        // Mispredict fixed in execute.
  input  wire        reserve_req_i,          // Load-and-reserve ready in load/store unit.
  input  wire        ld_miss_i,              // Data cache load miss done.
  input  wire        st_miss_i,              // Data cache store miss done.
  input  wire        miss_l2_intervened_i,   // That miss saw lateral cache intervention.
  input  wire [7:0]  miss_latency_i,         // Latency of that miss in cycles.
  input  wire        mtspr_dispatched_i,     // Special move dispatched.
  input  wire        barrier_done_i,         // Memory barrier completed.
  input  wire        io_barrier_done_i,      // Ordered-I/O barrier completed.
  input  wire        load_store_unit_result_i,      // Load/store unit result.
  input  wire        second_simple_int_unit_result_i, // Simple integer unit result.
  input  wire        floating_point_unit_result_i,  // Float unit result.
  input  wire        load_store_unit_disp_i,        // Dispatched to load/store unit.
  input  wire        second_simple_int_unit_disp_i, // Dispatched to simple integer unit.
  input  wire        floating_point_unit_disp_i,    // Dispatched to float unit.
  input  wire        branch_unit_idle_i,     // Branch unit idle this cycle.
  input  wire        multicycle_int_unit_idle_i, // Multi-cycle integer unit idle.
  input  wire        unaligned_load_i,       // Unaligned load seen.
  input  wire        ibreak_hit_i,           // Instruction breakpoint hit.
  input  wire        counter_two_event_i,    // Pre-selected event for counter two.
  input  wire        counter_three_event_i,  // Pre-selected event for counter three.
  input  wire        counter_four_event_i,   // Pre-selected event for counter four.
  // Pins from outside the core clock domain.
  input  wire        snoop_valid_i,          // Valid outside snoop request.
  input  wire        l2_intervention_signal_i, // Lateral cache intervention pin.
  // Interrupt and status.
  output reg         monitor_irq_o,          // Monitor interrupt taken by the core.
  output reg         irq_pending_o           // Interrupt condition recorded.
);

  // Control register and its decoded fields.
  // Bit 31 is the leftmost control bit.
  reg  [31:0] monitor_control_reg_r;  // Software-written monitor control.
  wire        monitor_irq_enable;     // Global monitor interrupt enable.
  wire        counter_negative_irq_ctl; // Counter-negative interrupt control.
  wire        freeze_on_interrupt;    // Stop counting once an interrupt occurs.
  wire [1:0]  timebase_bit_selector;  // Picks the time-base bit to watch.
  wire [5:0]  threshold;              // Miss latency threshold, units of four.
  wire [6:0]  sel_one;                // Counter one event select.
  wire [5:0]  sel_two;                // Counter two select; non-zero enables it.

  assign monitor_irq_enable       = monitor_control_reg_r[`CTL_IRQ_ENABLE];
  assign counter_negative_irq_ctl = monitor_control_reg_r[`CTL_NEG_IRQ];
  assign freeze_on_interrupt      = monitor_control_reg_r[`CTL_FREEZE];
  assign timebase_bit_selector    = monitor_control_reg_r[`CTL_TB_SEL_HI:`CTL_TB_SEL_LO];
  assign threshold                = monitor_control_reg_r[`CTL_THRESH_HI:`CTL_THRESH_LO];
  assign sel_one                  = monitor_control_reg_r[`CTL_SEL_ONE_HI:`CTL_SEL_ONE_LO];
  assign sel_two                  = monitor_control_reg_r[`CTL_SEL_TWO_HI:`CTL_SEL_TWO_LO];

  // Register decode of the move port.
  // Unmapped move-to numbers are ignored.
  wire wr_one;   // Move-to counter one.
  wire wr_two;   // Move-to counter two.
  wire wr_three; // Move-to counter three.
  wire wr_four;  // Move-to counter four.
  wire wr_ctl;   // Move-to monitor control.

  assign wr_one   = spr_wr_i && (spr_num_i == `SPR_EVENT_ONE);
  assign wr_two   = spr_wr_i && (spr_num_i == `SPR_EVENT_TWO);
  assign wr_three = spr_wr_i && (spr_num_i == `SPR_EVENT_THREE);
  assign wr_four  = spr_wr_i && (spr_num_i == `SPR_EVENT_FOUR);
  assign wr_ctl   = spr_wr_i && (spr_num_i == `SPR_MONITOR_CTL);

  // Two-flop synchronisers for the outside pins; only the second stage is read.
  // The pins are asynchronous to the core clock.
  reg [1:0] snoop_sync_r;   // Snoop request synchroniser.
  reg [1:0] l2i_sync_r;     // Intervention pin synchroniser.
  reg       l2i_prev_r;     // Last synchronised intervention level.

  // Pins pass two flops before any logic, then the intervention pin is edge detected.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snoop_sync_r <= 2'h0;
      l2i_sync_r   <= 2'h0;
      l2i_prev_r   <= 1'b0;
    end else begin
      snoop_sync_r <= {snoop_sync_r[0], snoop_valid_i};
      l2i_sync_r   <= {l2i_sync_r[0], l2_intervention_signal_i};
      l2i_prev_r   <= l2i_sync_r[1];
    end
  end

  // Counting an assertion, not a level, so a long intervention counts once.
  // The snoop pin, by contrast, counts per cycle.
  wire l2i_rise; // New assertion of the intervention pin.
  assign l2i_rise = l2i_sync_r[1] && !l2i_prev_r;

  // Time-base transition detector.
  // Rising and falling changes both count.
  reg  tb_bit;        // Currently selected time-base bit.
  reg  tb_prev_r;     // Its value one cycle earlier.

  // Selector values 0 to 3 pick bits 47, 51, 55, 63 counted from the left.
  always @* begin
    case (timebase_bit_selector)
      2'h0:    tb_bit = timebase_i[63-`TB_BIT_SEL0];
      2'h1:    tb_bit = timebase_i[63-`TB_BIT_SEL1];
      2'h2:    tb_bit = timebase_i[63-`TB_BIT_SEL2];
      default: tb_bit = timebase_i[63-`TB_BIT_SEL3];
    endcase
  end

  // Remember the selected bit; a change of selector may show as one extra transition.
  // A bit high just after reset adds no count; counter one holds until a control write selects it.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tb_prev_r <= 1'b0;
    end else begin
      tb_prev_r <= tb_bit;
    end
  end

  // Miss latency compare; the threshold field counts in steps of four cycles.
  // Only latencies strictly above it count.
  wire [7:0] thresh_cycles; // Threshold in cycles.
  wire       over_thresh;   // The current miss ran longer than the threshold.
  wire       ld_l2i;        // Long load miss with intervention.
  wire       st_l2i;        // Long store miss with intervention.
  wire       ld_plain;      // Long load miss without intervention.
  wire       st_plain;      // Long store miss without intervention.

  assign thresh_cycles = {threshold, 2'h0};
  assign over_thresh   = miss_latency_i > thresh_cycles;
  assign ld_l2i   = ld_miss_i && over_thresh && miss_l2_intervened_i;
  assign st_l2i   = st_miss_i && over_thresh && miss_l2_intervened_i;
  assign ld_plain = ld_miss_i && over_thresh && !miss_l2_intervened_i;
  assign st_plain = st_miss_i && over_thresh && !miss_l2_intervened_i;

  // Counter one increment chosen by its event select.
  // At most seven per cycle fits the 3-bit add.
  reg [2:0] inc_one; // Amount added to counter one this cycle.

  // Unlisted codes fall to the default and hold the counter like code zero.
  // Code 0x0A is the store twin of code 0x09.
  always @* begin
    case (sel_one)
      `EV_HOLD:         inc_one = 3'h0;
      `EV_CYCLES:       inc_one = 3'h1;
      `EV_INSTR_DONE:   inc_one = instr_completed_i;
      `EV_TB_TRANS:     inc_one = {2'h0, tb_bit ^ tb_prev_r};
      `EV_DISPATCHED:   inc_one = instr_dispatched_i;
      `EV_ICACHE_MISS:  inc_one = {2'h0, icache_miss_i};
      `EV_DTLB_MISS:    inc_one = {2'h0, dtlb_miss_i};
      `EV_BR_MISPRED:   inc_one = {2'h0, br_mispredict_i};
      `EV_RESERVE_REQ:  inc_one = {2'h0, reserve_req_i};
      `EV_LD_MISS_L2I:  inc_one = {2'h0, ld_l2i};
      `EV_ST_MISS_L2I:  inc_one = {2'h0, st_l2i};
      `EV_MTSPR_DISP:   inc_one = {2'h0, mtspr_dispatched_i};
      `EV_BARRIER_DONE: inc_one = {2'h0, barrier_done_i};
      `EV_IO_BARRIER:   inc_one = {2'h0, io_barrier_done_i};
      `EV_INT_DONE:     inc_one = int_completed_i;
      `EV_FP_DONE:      inc_one = fp_completed_i;
      `EV_LSU_RESULT:   inc_one = {2'h0, load_store_unit_result_i};
      `EV_SCIU_RESULT:  inc_one = {2'h0, second_simple_int_unit_result_i};
      `EV_FPU_RESULT:   inc_one = {2'h0, floating_point_unit_result_i};
      `EV_LSU_DISP:     inc_one = {2'h0, load_store_unit_disp_i};
      `EV_SCIU_DISP:    inc_one = {2'h0, second_simple_int_unit_disp_i};
      `EV_FPU_DISP:     inc_one = {2'h0, floating_point_unit_disp_i};
      `EV_SNOOP:        inc_one = {2'h0, snoop_sync_r[1]};
      `EV_LD_MISS:      inc_one = {2'h0, ld_plain};
      `EV_ST_MISS:      inc_one = {2'h0, st_plain};
      `EV_BRU_IDLE:     inc_one = {2'h0, branch_unit_idle_i};
      `EV_MCIU_IDLE:    inc_one = {2'h0, multicycle_int_unit_idle_i};
      `EV_L2_INTERVENE: inc_one = {2'h0, l2i_rise};
      `EV_UNALIGNED_LD: inc_one = {2'h0, unaligned_load_i};
      `EV_IBREAK_HIT:   inc_one = {2'h0, ibreak_hit_i};
      default:          inc_one = 3'h0;
    endcase
  end

  // Counter values and the run gate shared by all four.
  // Freeze off: counters run past an interrupt.
  wire [31:0] cnt_one;   // Counter one value.
  wire [31:0] cnt_two;   // Counter two value.
  wire [31:0] cnt_three; // Counter three value.
  wire [31:0] cnt_four;  // Counter four value.
  reg         irq_pending_r; // Interrupt condition recorded.
  wire        run;           // All counters may advance.

  // Counting runs from reset until an interrupt, when freezing is on.
  // Counter two also needs a non-zero select.
  assign run = !(freeze_on_interrupt && irq_pending_r);

  // Counter one counts the selected event.
  event_counter_cell u_cnt_one (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .load_i     (wr_one),
    .load_val_i (spr_wdata_i),
    .run_i      (run),
    .inc_i      (inc_one),
    .count_o    (cnt_one)
  );

  // Counter two counts its pre-selected event.
  event_counter_cell u_cnt_two (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .load_i     (wr_two),
    .load_val_i (spr_wdata_i),
    .run_i      (run && (sel_two != 6'h00)),
    .inc_i      ({2'h0, counter_two_event_i}),
    .count_o    (cnt_two)
  );

  // Counters three and four need no select; they stop only on the shared freeze gate.
  event_counter_cell u_cnt_three (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .load_i     (wr_three),
    .load_val_i (spr_wdata_i),
    .run_i      (run),
    .inc_i      ({2'h0, counter_three_event_i}),
    .count_o    (cnt_three)
  );

  event_counter_cell u_cnt_four (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .load_i     (wr_four),
    .load_val_i (spr_wdata_i),
    .run_i      (run),
    .inc_i      ({2'h0, counter_four_event_i}),
    .count_o    (cnt_four)
  );

  // Any counter with its sign bit set is negative.
  // One shared negative control covers all four.
  wire any_negative; // At least one counter is at or above 0x8000_0000.
  wire irq_set;      // A new interrupt condition this cycle.

  assign any_negative = cnt_one[31] | cnt_two[31] | cnt_three[31] | cnt_four[31];
  assign irq_set = any_negative && counter_negative_irq_ctl && monitor_irq_enable;

  // Control register write, and the recorded condition it clears.
  // A fresh condition in the cycle of a control write still wins, so no
  // interrupt is lost; software must clear the negative counter first.
  // A control write can restart a frozen count.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      monitor_control_reg_r <= `MONITOR_CTL_RESET;
      irq_pending_r         <= 1'b0;
    end else begin
      if (wr_ctl) begin
        monitor_control_reg_r <= spr_wdata_i;
      end
      if (irq_set) begin
        irq_pending_r <= 1'b1;
      end else if (wr_ctl) begin
        irq_pending_r <= 1'b0;
      end
    end
  end

  // The core only sees the request while its external mask bit is set;
  // the recorded condition waits here meanwhile.
  // Registering keeps the request glitch-free.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      monitor_irq_o <= 1'b0;
      irq_pending_o <= 1'b0;
    end else begin
      monitor_irq_o <= irq_pending_r && external_irq_mask_bit_i;
      irq_pending_o <= irq_pending_r;
    end
  end

  // Move-from answers one cycle after the strobe; unknown numbers read zero.
  // A same-cycle write is seen on the next read.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spr_rdata_o  <= 32'h0000_0000;
      spr_rvalid_o <= 1'b0;
    end else begin
      spr_rvalid_o <= spr_rd_i;
      if (spr_rd_i) begin
        case (spr_num_i)
          `SPR_EVENT_ONE:   spr_rdata_o <= cnt_one;
          `SPR_EVENT_TWO:   spr_rdata_o <= cnt_two;
          `SPR_EVENT_THREE: spr_rdata_o <= cnt_three;
          `SPR_EVENT_FOUR:  spr_rdata_o <= cnt_four;
          `SPR_MONITOR_CTL: spr_rdata_o <= monitor_control_reg_r;
          default:          spr_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // perf_event_counters
`default_nettype wire

/* design/perf_event_defs.vh */
// Constants for the event counter block: register numbers, field positions, event codes.
`ifndef PERF_EVENT_DEFS_VH
`define PERF_EVENT_DEFS_VH

// Special-purpose register numbers seen by the move instructions.
`define SPR_NUM_W          10
`define SPR_EVENT_ONE      10'h3B9
`define SPR_EVENT_TWO      10'h3BA
`define SPR_EVENT_THREE    10'h3BD
`define SPR_EVENT_FOUR     10'h3BE
`define SPR_MONITOR_CTL    10'h3B0

// Reset values.
`define COUNTER_RESET      32'h0000_0000
`define MONITOR_CTL_RESET  32'h0000_0000

// Monitor control register fields (bit 31 is the leftmost control bit).
`define CTL_IRQ_ENABLE     26
`define CTL_FREEZE         25
`define CTL_TB_SEL_HI      24
`define CTL_TB_SEL_LO      23
`define CTL_THRESH_HI      21
`define CTL_THRESH_LO      16
`define CTL_NEG_IRQ        14
`define CTL_SEL_ONE_HI     12
`define CTL_SEL_ONE_LO     6
`define CTL_SEL_TWO_HI     5
`define CTL_SEL_TWO_LO     0

// Time-base bit positions picked by selector values 0 to 3.
`define TB_BIT_SEL0        47
`define TB_BIT_SEL1        51
`define TB_BIT_SEL2        55
`define TB_BIT_SEL3        63

// Counter one event codes.
`define EV_HOLD            7'h00
`define EV_CYCLES          7'h01
`define EV_INSTR_DONE      7'h02
`define EV_TB_TRANS        7'h03
`define EV_DISPATCHED      7'h04
`define EV_ICACHE_MISS     7'h05
`define EV_DTLB_MISS       7'h06
`define EV_BR_MISPRED      7'h07
`define EV_RESERVE_REQ     7'h08
`define EV_LD_MISS_L2I     7'h09
`define EV_ST_MISS_L2I     7'h0A
`define EV_MTSPR_DISP      7'h0B
`define EV_BARRIER_DONE    7'h0C
`define EV_IO_BARRIER      7'h0D
`define EV_INT_DONE        7'h0E
`define EV_FP_DONE         7'h0F
`define EV_LSU_RESULT      7'h10
`define EV_SCIU_RESULT     7'h11
`define EV_FPU_RESULT      7'h12
`define EV_LSU_DISP        7'h13
`define EV_SCIU_DISP       7'h14
`define EV_FPU_DISP        7'h15
`define EV_SNOOP           7'h16
`define EV_LD_MISS         7'h17
`define EV_ST_MISS         7'h18
`define EV_BRU_IDLE        7'h19
`define EV_MCIU_IDLE       7'h1A
`define EV_L2_INTERVENE    7'h1C
`define EV_UNALIGNED_LD    7'h1D
`define EV_IBREAK_HIT      7'h1F

`endif

/* tb/event_source_model.sv */
// Pipeline event source model: steady per-cycle counts, event pulses and a time base.
`timescale 1ns/1ps
`default_nettype none

module event_source_model (
  input  wire logic        clk_i,    // Core clock.
  input  wire logic        run_i,    // Pipeline busy: events flow while high.
  output var  logic [11:0] counts_o, // Completed, integer, float, dispatched counts.
  output var  logic        pulse_o,  // One event per cycle on every single-bit source but store miss and miss intervention.
  output var  logic [63:0] tb_o      // Time base, advancing once per clock.
);
  // The time base runs free; its low bit toggles every cycle.
  initial tb_o = 64'h0;
  always @(posedge clk_i) tb_o <= tb_o + 64'h1;

  // Distinct steady counts, so a wrong source choice shows as a wrong rate.
  always @* begin
    counts_o = run_i ? {3'h3, 3'h2, 3'h1, 3'h4} : 12'h000;
    pulse_o  = run_i;
  end
endmodule // event_source_model
`default_nettype wire

/* tb/perf_event_counters_assertions.sv */
// Checker for the register port and interrupt outputs of the event counter block.
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_defs.vh"

module perf_event_counters_assertions (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        spr_wr_i,
  input wire logic        spr_rd_i,
  input wire logic [9:0]  spr_num_i,
  input wire logic [31:0] spr_wdata_i,
  input wire logic [31:0] spr_rdata_o,
  input wire logic        spr_rvalid_o,
  input wire logic        external_irq_mask_bit_i,
  input wire logic        monitor_irq_o,
  input wire logic        irq_pending_o
);
  logic [31:0] ctl_r;  // Shadow of the control register, so enables can be judged.
  logic        ctl_wr; // Move-to aimed at the control register.
  logic        mapped; // Number decodes to a real register.
  assign ctl_wr = spr_wr_i && (spr_num_i == `SPR_MONITOR_CTL);
  assign mapped = spr_num_i inside {`SPR_EVENT_ONE, `SPR_EVENT_TWO, `SPR_EVENT_THREE,
                                    `SPR_EVENT_FOUR, `SPR_MONITOR_CTL};

  // Track the control value the block should hold after each move-to.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) ctl_r <= 32'h0000_0000;
    else if (ctl_wr) ctl_r <= spr_wdata_i;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_read_answer: assert property (spr_rd_i |=> spr_rvalid_o)
    else $error("read not answered in the next cycle");
  a_rvalid_cause: assert property (spr_rvalid_o |-> $past(spr_rd_i))
    else $error("read data valid without a read");
  a_unmapped_zero: assert property (spr_rd_i && !mapped |=> spr_rdata_o == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_ctl_readback: assert property (spr_rd_i && spr_num_i == `SPR_MONITOR_CTL |=>
    spr_rdata_o == $past(ctl_r)) else $error("control read does not match last write");
  a_irq_gate_mask: assert property (monitor_irq_o ==
    (irq_pending_o && $past(external_irq_mask_bit_i)))
    else $error("interrupt output does not follow pending and mask");
  a_pending_cause: assert property ($rose(irq_pending_o) |->
    $past(ctl_r[`CTL_IRQ_ENABLE] && ctl_r[`CTL_NEG_IRQ], 2)) else $error("pending without enables");
  a_pending_clear: assert property (ctl_wr && !ctl_r[`CTL_IRQ_ENABLE] |-> ##2 !irq_pending_o)
    else $error("pending not cleared by control write");
  a_irq_stays: assert property (monitor_irq_o && !$past(ctl_wr) &&
    external_irq_mask_bit_i |=> monitor_irq_o)
    else $error("taken interrupt dropped without a control write");

  c_irq: cover property (monitor_irq_o);
  c_unmapped: cover property (spr_rd_i && !mapped);
  c_pending: cover property ($rose(irq_pending_o));
endmodule // perf_event_counters_assertions

bind perf_event_counters perf_event_counters_assertions u_chk (.clk_i, .rstn_i, .spr_wr_i,
  .spr_rd_i, .spr_num_i, .spr_wdata_i, .spr_rdata_o, .spr_rvalid_o,
  .external_irq_mask_bit_i, .monitor_irq_o, .irq_pending_o);
`default_nettype wire

/* tb/test_perf_event_counters.sv */
// Register-level testbench for the event counter block.
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_defs.vh"

module test_perf_event_counters;
  logic        clk_i, rstn_i, spr_wr_i, spr_rd_i, spr_rvalid_o, run, p;
  logic        external_irq_mask_bit_i, monitor_irq_o, irq_pending_o;
  logic [9:0]  spr_num_i;
  logic [31:0] spr_wdata_i, spr_rdata_o, v0, v1;
  logic [11:0] cnt;
  logic [63:0] tb;
  logic [6:0]  e;
  logic [9:0]  nums [4] = '{`SPR_EVENT_ONE, `SPR_EVENT_TWO, `SPR_EVENT_THREE, `SPR_EVENT_FOUR};
  int          fail_count = 0, samples_checked = 0, c;

  event_source_model u_src (.clk_i, .run_i(run), .counts_o(cnt), .pulse_o(p), .tb_o(tb));
  perf_event_counters u_dut (.clk_i, .rstn_i, .spr_wr_i, .spr_rd_i, .spr_num_i, .spr_wdata_i,
    .spr_rdata_o, .spr_rvalid_o, .external_irq_mask_bit_i, .timebase_i(tb),
    .instr_completed_i(cnt[11:9]), .int_completed_i(cnt[8:6]), .fp_completed_i(cnt[5:3]),
    .instr_dispatched_i(cnt[2:0]), .icache_miss_i(p), .dtlb_miss_i(p), .br_mispredict_i(p),
    .reserve_req_i(p), .ld_miss_i(p), .st_miss_i(1'b0), .miss_l2_intervened_i(1'b0),
    .miss_latency_i(8'hFF), .mtspr_dispatched_i(p), .barrier_done_i(p), .io_barrier_done_i(p),
    .load_store_unit_result_i(p), .second_simple_int_unit_result_i(p),
    .floating_point_unit_result_i(p), .load_store_unit_disp_i(p),
    .second_simple_int_unit_disp_i(p), .floating_point_unit_disp_i(p),
    .branch_unit_idle_i(p), .multicycle_int_unit_idle_i(p), .unaligned_load_i(p),
    .ibreak_hit_i(p), .counter_two_event_i(p), .counter_three_event_i(p),
    .counter_four_event_i(p), .snoop_valid_i(p), .l2_intervention_signal_i(p),
    .monitor_irq_o, .irq_pending_o);

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Compare and count; a mismatch is reported at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    spr_wr_i = 1'b1;
    spr_num_i = n;
    spr_wdata_i = d;
    tick(1);
    spr_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [9:0] n, output logic [31:0] d);
    spr_rd_i = 1'b1;
    spr_num_i = n;
    tick(1);
    spr_rd_i = 1'b0;
    check("read valid", 32'h1, {31'h0, spr_rvalid_o});
    d = spr_rdata_o;
    tick(1);
  endtask
  // Two reads exactly eight cycles apart give the per-eight-cycle growth.
  task automatic rate(input logic [9:0] n, output logic [31:0] d);
    rd(n, v0);
    tick(6);
    rd(n, v1);
    d = v1 - v0;
  endtask
  // Expected growth per cycle of counter one for each select code under the model.
  function automatic logic [31:0] inc_of(input logic [6:0] s);
    case (s)
      7'h02: return 32'h3;
      7'h04: return 32'h4;
      7'h0E: return 32'h2;
      7'h00, 7'h09, 7'h0A, 7'h18, 7'h1B, 7'h1C, 7'h1E, 7'h7F: return 32'h0;
      default: return 32'h1;
    endcase
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {rstn_i, spr_wr_i, spr_rd_i, run, external_irq_mask_bit_i} = 5'h00;
    spr_num_i = 10'h000;
    spr_wdata_i = 32'h0000_0000;
    tick(10);
    rstn_i = 1'b1;
    // Reset values and write then read, one idle cycle apart, of each counter.
    for (c = 0; c < 4; c++) begin
      rd(nums[c], v0);
      check("reset value", 32'h0000_0000, v0);
      wr(nums[c], 32'h1234_5670 + c);
      rd(nums[c], v0);
      check("counter readback", 32'h1234_5670 + c, v0);
    end
    rd(10'h3BB, v0);
    check("unmapped read", 32'h0000_0000, v0);
    $display("test registers done");
    // Select codes 0x00 to 0x1F and 0x7F of counter one, time-base selector on the fastest bit.
    run = 1'b1;
    for (c = 0; c <= 32; c++) begin
      e = (c == 32) ? 7'h7F : c[6:0];
      wr(`SPR_MONITOR_CTL, (32'h3 << `CTL_TB_SEL_LO) | ({25'h0, e} << `CTL_SEL_ONE_LO));
      tick(3);
      rate(`SPR_EVENT_ONE, v0);
      check("event rate", inc_of(e) << 3, v0);
    end
    $display("test events done");
    // Enable alone: crossing into the sign bit must stay silent.
    wr(`SPR_EVENT_ONE, 32'h7FFF_FFFC);
    wr(`SPR_MONITOR_CTL, 32'h0400_0040);
    tick(12);
    check("pending without control", 32'h0, {31'h0, irq_pending_o});
    // Both enables and freeze, core mask clear.
    wr(`SPR_EVENT_ONE, 32'h7FFF_FFFC);
    wr(`SPR_MONITOR_CTL, 32'h0600_4040);
    for (c = 0; c < 40 && irq_pending_o !== 1'b1; c++) tick(1);
    if (c == 40) begin
      fail_count++;
      conclude();
    end
    check("irq while masked", 32'h0, {31'h0, monitor_irq_o});
    rate(`SPR_EVENT_ONE, v0);
    check("frozen counter one", 32'h0, v0);
    check("sign bit", 32'h1, {31'h0, v1[31]});
    rate(`SPR_EVENT_THREE, v0);
    check("frozen counter three", 32'h0, v0);
    rd(`SPR_MONITOR_CTL, v0);
    check("control readback", 32'h0600_4040, v0);
    external_irq_mask_bit_i = 1'b1;
    tick(2);
    check("irq taken", 32'h1, {31'h0, monitor_irq_o});
    // A set in the clearing cycle may win, so the control is written twice.
    wr(`SPR_MONITOR_CTL, 32'h0000_0000);
    wr(`SPR_MONITOR_CTL, 32'h0000_0000);
    tick(3);
    check("pending cleared", 32'h0, {31'h0, irq_pending_o});
    $display("test interrupt done");
    conclude();
  end
endmodule // test_perf_event_counters
`default_nettype wire
